/* File: core/scg_pkg.sv */
// Package with constants, enumerations and register map of the system clock generator.
package scg_pkg;

  // Oscillator source chosen by the flash configuration.
  typedef enum logic [2:0] {
    SCG_SRC_XTAL_LOW,
    SCG_SRC_XTAL_MED,
    SCG_SRC_XTAL_HIGH,
    SCG_SRC_RC,
    SCG_SRC_WDT,
    SCG_SRC_EXT
  } scg_src_e;

  // Wake-up sequence states.
  typedef enum logic [1:0] {
    SCG_WAKE_OSC,
    SCG_WAKE_DELAY,
    SCG_RUN
  } scg_wake_e;

  // Source frequency limits and nominal values in Hz.
  localparam int unsigned XTAL_LOW_MIN_HZ  = 20000;
  localparam int unsigned XTAL_LOW_MAX_HZ  = 100000;
  localparam int unsigned XTAL_MED_MAX_HZ  = 4000000;
  localparam int unsigned XTAL_HIGH_MAX_HZ = 18000000;
  localparam int unsigned EXT_MAX_HZ       = 18000000;
  localparam int unsigned RC_NOMINAL_HZ    = 7373000;
  localparam int unsigned WDT_NOMINAL_HZ   = 400000;

  // Wake-up timing.
  localparam int unsigned WAKE_XTAL_CYC   = 992;
  localparam int unsigned WAKE_OTHER_CYC  = 224;
  localparam int unsigned WAKE_DELAY_NS   = 60000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned WAKE_DELAY_CYC  = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index.
  localparam logic [11:0] IDX_DIVIDE = 12'h095;
  localparam logic [11:0] IDX_TRIM   = 12'h096;
  localparam logic [11:0] IDX_STATUS = 12'h097;
  localparam logic [11:0] ADDR_DIVIDE = 12'h254;
  localparam logic [11:0] ADDR_TRIM   = 12'h258;
  localparam logic [11:0] ADDR_STATUS = 12'h25c;

  // Tuning register layout.
  localparam int unsigned TRIM_RC_BIT    = 7;
  localparam int unsigned TRIM_CLKEN_BIT = 6;
  localparam int unsigned TRIM_TUNE_MSB  = 5;
  localparam logic [7:0]  TRIM_FACTORY   = 8'h20;

  // Status register layout.
  localparam int unsigned STAT_RUN_BIT   = 0;
  localparam int unsigned STAT_CLKO_BIT  = 1;
  localparam int unsigned STAT_SRC_LSB   = 4;

  localparam logic [7:0]  DIVIDE_RESET   = 8'h00;

endpackage : scg_pkg

/* File: core/scg_sync.sv */
// Two-flop synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
module scg_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;

  // Each bit gets its own pair of flops; only the second stage is visible.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        stage1_ff[i] <= 1'b0;
        syncOut[i]   <= 1'b0;
      end else begin
        stage1_ff[i] <= asyncIn[i];
        syncOut[i]   <= stage1_ff[i];
      end
    end
  end

endmodule : scg_sync

/* File: core/scg_divider.sv */
// Tick divider that forms cpu clock ticks from oscillator ticks.
`timescale 1ns/10ps
module scg_divider #(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             inTick,
  input  wire logic [DIV_W-1:0] divValue,
  output logic                  outTick
);

  logic [DIV_W:0] cnt_ff;
  logic [DIV_W:0] period;

  // A value of zero passes every tick; otherwise the period is twice the value.
  assign period = (divValue == '0) ? (DIV_W+1)'(1) : {divValue, 1'b0};

  // Compare with >= so a new value written mid-count never stalls the divider.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      outTick <= 1'b0;
    end else if (clear) begin
      cnt_ff  <= '0;
      outTick <= 1'b0;
    end else if (inTick) begin
      if (cnt_ff + (DIV_W+1)'(1) >= period) begin
        cnt_ff  <= '0;
        outTick <= 1'b1;
      end else begin
        cnt_ff  <= cnt_ff + (DIV_W+1)'(1);
        outTick <= 1'b0;
      end
    end else begin
      outTick <= 1'b0;
    end
  end

endmodule : scg_divider

/* File: core/scg_clock_gen.sv */
// System clock generator: source select, divider, wake-up timer, clock output, APB registers.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps

// Summary of operation
// - Peripheral tick comes once per two cpu clock ticks.
// - A machine cycle spans exactly two cpu clock ticks.
// - Oscillator clock is chosen from four sources by flash configuration.
// - Crystal offers low, medium and high frequency ranges.
// - Clock output only when crystal unused and real-time clock not on crystal.
// - Clock output driven only while the output enable bit is set.
// - Clock output toggles on each cpu clock tick, so it runs at half the cpu clock rate.
// - Six-bit tuning field adjusts the RC oscillator and is software writable.
// - Only power-on reset loads the tuning register with the factory value.
// - RC oscillator runs at nominal 7.373 MHz with factory tuning.
// - Watchdog oscillator, nominal 400 kHz, is selectable as source.
// - External clock input accepted from 0 Hz up to 18 MHz; sampled at 20 MHz, the code takes its edges only below 10 MHz.
// - Crystal source holds cpu clock 992 oscillator cycles plus 60 to 100 us.
// - Other sources hold cpu clock 224 oscillator cycles plus the same delay.
// - Cpu clock is the divider output fed by the oscillator clock.
// - Divide value divides up to 510 and may change at any time.
module scg_clock_gen
  import scg_pkg::*;
#(
  parameter logic [7:0] FACTORY_TRIM = scg_pkg::TRIM_FACTORY
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             otherRst_n,
  input  wire logic             wakeReq,
  input  wire scg_pkg::scg_src_e srcSel,
  input  wire logic             rtcOnXtal,
  input  wire logic             wdtOscIn,
  input  wire logic             rcOscIn,
  input  wire logic             xtalIn,
  input  wire logic             extClkIn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic                  cpuClkTick_ff,
  output logic                  periphTick_ff,
  output logic                  machCycTick_ff,
  output logic                  clkOutPin_ff,
  output logic                  clkOutPinOe_ff,
  output logic      [5:0]       rcTune_ff
);
  import scg_pkg::*;

  logic [3:0]  oscSync;
  logic [3:0]  oscDly_ff;
  logic [3:0]  oscRise;
  logic        otherRstSync_n;
  logic        oscTick;
  logic        srcIsXtal;
  logic        divPulse;
  logic        cpuTick;
  logic        clkOutAllowed;
  logic        phase_ff;
  logic [7:0]  trimReg_ff;
  logic [7:0]  divideReg_ff;
  scg_wake_e   wakeState_ff;
  logic [9:0]  oscCnt_ff;
  logic [10:0] delayCnt_ff;
  logic [9:0]  wakeTarget;
  logic        setupPhase;
  logic        accessDone;
  logic        addrHit;
  logic        wrTrim;
  logic        wrDivide;
  logic        wakeRestart;

  // Pin-side oscillators are asynchronous to clk and pass two flops first.
  scg_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({otherRst_n, extClkIn, xtalIn, rcOscIn, wdtOscIn}),
    .syncOut ({otherRstSync_n, oscSync})
  );

  // Edge detect runs on the synchronised copy only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscDly_ff <= '0;
    end else begin
      oscDly_ff <= oscSync;
    end
  end

  assign oscRise = oscSync & ~oscDly_ff;

  // source select
  // Sampling at 20 MHz limits usable source rates below half the clk rate.
  always_comb begin
    oscTick   = 1'b0;
    srcIsXtal = 1'b0;
    unique case (srcSel)
      SCG_SRC_XTAL_LOW, SCG_SRC_XTAL_MED, SCG_SRC_XTAL_HIGH: begin
        oscTick   = oscRise[2];
        srcIsXtal = 1'b1;
      end
      SCG_SRC_RC: begin
        oscTick = oscRise[1];
      end
      SCG_SRC_WDT: begin
        oscTick = oscRise[0];
      end
      SCG_SRC_EXT: begin
        oscTick = oscRise[3];
      end
      default: begin
        oscTick = 1'b0;
      end
    endcase
  end

  // crystal or other wake count
  // Crystals get the longer count because they take far longer to settle.
  assign wakeTarget = srcIsXtal ? 10'(WAKE_XTAL_CYC) : 10'(WAKE_OTHER_CYC);

  assign wakeRestart = !otherRstSync_n || wakeReq;

  // Wake-up sequence: count oscillator ticks, then the fixed delay, then run.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeState_ff <= SCG_WAKE_OSC;
      oscCnt_ff    <= '0;
      delayCnt_ff  <= '0;
    end else if (wakeRestart) begin
      wakeState_ff <= SCG_WAKE_OSC;
      oscCnt_ff    <= '0;
      delayCnt_ff  <= '0;
    end else begin
      unique case (wakeState_ff)
        SCG_WAKE_OSC: begin
          if (oscTick) begin
            if (oscCnt_ff == wakeTarget - 10'd1) begin
              wakeState_ff <= SCG_WAKE_DELAY;
              oscCnt_ff    <= '0;
            end else begin
              oscCnt_ff <= oscCnt_ff + 10'd1;
            end
          end
        end
        SCG_WAKE_DELAY: begin
          if (delayCnt_ff == 11'(WAKE_DELAY_CYC - 1)) begin
            wakeState_ff <= SCG_RUN;
            delayCnt_ff  <= '0;
          end else begin
            delayCnt_ff <= delayCnt_ff + 11'd1;
          end
        end
        SCG_RUN: begin
          wakeState_ff <= SCG_RUN;
        end
        // An unused state code falls back to counting, so a stray upset restarts wake-up.
        default: begin
          wakeState_ff <= SCG_WAKE_OSC;
        end
      endcase
    end
  end

  // divide value live
  // The divider clears with the other reset so a new run starts on a whole period.
  scg_divider #(
    .DIV_W (8)
  ) u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .clear    (!otherRstSync_n),
    .inTick   (oscTick),
    .divValue (divideReg_ff),
    .outTick  (divPulse)
  );

  // gate cpu clock
  // Gating a tick pulse synchronously leaves no runt at either end.
  assign cpuTick = divPulse && (wakeState_ff == SCG_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff       <= 1'b0;
      cpuClkTick_ff  <= 1'b0;
      periphTick_ff  <= 1'b0;
      machCycTick_ff <= 1'b0;
    end else begin
      cpuClkTick_ff  <= cpuTick;
      periphTick_ff  <= cpuTick && phase_ff;
      machCycTick_ff <= cpuTick && phase_ff;
      if (!otherRstSync_n) begin
        phase_ff <= 1'b0;
      end else if (cpuTick) begin
        phase_ff <= !phase_ff;
      end
    end
  end

  assign clkOutAllowed = !srcIsXtal && !rtcOnXtal && trimReg_ff[TRIM_CLKEN_BIT];

  // half cpu rate
  // Output is parked low while disabled so re-enabling starts on a clean edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkOutPin_ff   <= 1'b0;
      clkOutPinOe_ff <= 1'b0;
    end else begin
      clkOutPinOe_ff <= clkOutAllowed;
      if (!clkOutAllowed) begin
        clkOutPin_ff <= 1'b0;
      end else if (cpuTick) begin
        clkOutPin_ff <= !clkOutPin_ff;
      end
    end
  end

  // APB decode: answer registered in setup, completing in the first access cycle.
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign addrHit    = (paddr == ADDR_TRIM) || (paddr == ADDR_DIVIDE) || (paddr == ADDR_STATUS);
  assign wrTrim     = accessDone && pwrite && (paddr == ADDR_TRIM);
  assign wrDivide   = accessDone && pwrite && (paddr == ADDR_DIVIDE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !addrHit;
      prdata  <= '0;
      // Status is rebuilt at each setup so software never sees a stale copy.
      if (setupPhase && !pwrite) begin
        if (paddr == ADDR_TRIM) begin
          prdata <= {24'h000000, trimReg_ff};
        end else if (paddr == ADDR_DIVIDE) begin
          prdata <= {24'h000000, divideReg_ff};
        end else if (paddr == ADDR_STATUS) begin
          prdata[STAT_RUN_BIT]              <= (wakeState_ff == SCG_RUN);
          prdata[STAT_CLKO_BIT]             <= clkOutPinOe_ff;
          prdata[STAT_SRC_LSB +: 3]         <= srcSel;
        end
      end
    end
  end

  // tuning field
  // Only the power-on reset touches this; the other reset is deliberately ignored.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trimReg_ff <= FACTORY_TRIM;
      rcTune_ff  <= FACTORY_TRIM[TRIM_TUNE_MSB:0];
    end else begin
      rcTune_ff <= trimReg_ff[TRIM_TUNE_MSB:0];
      if (wrTrim) begin
        trimReg_ff <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divideReg_ff <= DIVIDE_RESET;
    end else if (!otherRstSync_n) begin
      divideReg_ff <= DIVIDE_RESET;
    end else if (wrDivide) begin
      divideReg_ff <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_periph_rate: assert property (cpuTick && phase_ff |=> periphTick_ff)
    else $error("peripheral tick missing on second cpu tick");
  chk_periph_only: assert property (periphTick_ff |-> $past(cpuTick) && $past(phase_ff))
    else $error("peripheral tick without cause");
  chk_machine_cycle: assert property (machCycTick_ff |-> !$past(cpuTick, 2))
    else $error("machine cycle shorter than two cpu ticks");
  chk_source_tick: assert property (oscTick |-> (oscRise != 4'h0))
    else $error("oscillator tick without a source edge");
  chk_clkout_src: assert property (clkOutPinOe_ff |-> $past(!srcIsXtal && !rtcOnXtal))
    else $error("clock output while crystal in use");
  chk_clkout_enable: assert property (clkOutPin_ff |-> $past(trimReg_ff[TRIM_CLKEN_BIT]))
    else $error("clock output high while disabled");
  chk_clkout_toggle: assert property (cpuTick && clkOutAllowed |=>
    clkOutPin_ff != $past(clkOutPin_ff))
    else $error("clock output did not toggle on cpu tick");
  chk_trim_write: assert property (wrTrim |=> ##1 rcTune_ff == $past(pwdata[5:0], 2))
    else $error("tuning field not updated");
  chk_trim_keep: assert property (!otherRstSync_n && !wrTrim |=> $stable(trimReg_ff))
    else $error("tuning register changed by other reset");
  chk_wake_count: assert property (wakeState_ff == SCG_WAKE_OSC ##1
    wakeState_ff == SCG_WAKE_DELAY |-> $past(oscCnt_ff) == wakeTarget - 10'd1)
    else $error("wake count left early");
  chk_wake_delay: assert property (wakeState_ff == SCG_WAKE_DELAY ##1 wakeState_ff == SCG_RUN
    |-> $past(delayCnt_ff) == 11'(WAKE_DELAY_CYC - 1))
    else $error("wake delay too short");
  chk_cpu_gated: assert property (wakeState_ff != SCG_RUN |=> !cpuClkTick_ff)
    else $error("cpu tick during wake-up");
  chk_div_source: assert property (divPulse |-> $past(oscTick))
    else $error("divider pulse without oscillator tick");

  // Output, divider and wake-up checks on what the registers hold one cycle later.
  chk_clkout_off: assert property (!clkOutAllowed |=> !clkOutPinOe_ff && !clkOutPin_ff)
    else $error("clock output active while not allowed");
  chk_cpu_source: assert property (cpuClkTick_ff |-> $past(divPulse))
    else $error("cpu tick without divider pulse");
  chk_div_write: assert property (wrDivide && otherRstSync_n |=> divideReg_ff == $past(pwdata[7:0]))
    else $error("divide value not taken");
  chk_wake_restart: assert property (wakeRestart |=> wakeState_ff == SCG_WAKE_OSC)
    else $error("wake-up not restarted");
  chk_xtal_clkout: assert property (srcIsXtal |=> !clkOutPinOe_ff)
    else $error("clock output enabled with crystal source");

  cov_run: cover property (wakeState_ff == SCG_WAKE_DELAY ##1 wakeState_ff == SCG_RUN);
  cov_clkout: cover property (clkOutPinOe_ff && $rose(clkOutPin_ff));
  cov_divide: cover property (wrDivide ##1 divideReg_ff != DIVIDE_RESET);
  cov_trim: cover property (wrTrim);
  cov_restart: cover property (wakeRestart ##1 !wakeRestart);

endmodule : scg_clock_gen

/* File: tb/system_clock_generation_tb_top.sv */
// Self-checking testbench for the system clock generator.
`timescale 1ns/10ps
module system_clock_generation_tb_top;
  import scg_pkg::*;

  logic             clk;
  logic             rst_n;
  logic             otherRst_n;
  logic             wakeReq;
  scg_src_e         srcSel;
  logic             rtcOnXtal;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [11:0]      paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             cpuClkTick_ff;
  logic             periphTick_ff;
  logic             machCycTick_ff;
  logic             clkOutPin_ff;
  logic             clkOutPinOe_ff;
  logic [5:0]       rcTune_ff;
  logic [2:0]       oscPh;
  logic             prevPin;
  int               cyc;
  int               cpuCnt;
  int               perCnt;
  int               macCnt;
  int               togCnt;
  int               oeCnt;
  int               failures;
  int               checksDone;

  scg_clock_gen u_scg_clock_gen (
    .clk(clk), .rst_n(rst_n), .otherRst_n(otherRst_n), .wakeReq(wakeReq),
    .srcSel(srcSel), .rtcOnXtal(rtcOnXtal), .wdtOscIn(oscPh[2]), .rcOscIn(oscPh[1]),
    .xtalIn(oscPh[1]), .extClkIn(oscPh[1]), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuClkTick_ff(cpuClkTick_ff), .periphTick_ff(periphTick_ff),
    .machCycTick_ff(machCycTick_ff), .clkOutPin_ff(clkOutPin_ff),
    .clkOutPinOe_ff(clkOutPinOe_ff), .rcTune_ff(rcTune_ff)
  );

  // Clock of 50 ns period.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The watchdog source runs at an eighth of the clock and the others at a quarter.
  // A wrong selection to or from the watchdog source therefore shows up in the measured wake-up time.
  // sources below 12 MHz
  always @(posedge clk) begin
    oscPh   <= oscPh + 3'h1;
    cyc     <= cyc + 1;
    prevPin <= clkOutPin_ff;
    if (cpuClkTick_ff === 1'b1) cpuCnt <= cpuCnt + 1;
    if (periphTick_ff === 1'b1) perCnt <= perCnt + 1;
    if (machCycTick_ff === 1'b1) macCnt <= macCnt + 1;
    if (clkOutPin_ff !== prevPin) togCnt <= togCnt + 1;
    if (clkOutPinOe_ff === 1'b1) oeCnt <= oeCnt + 1;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Counts within one of the expected value pass; the phase of the oscillator is free.
  task checkNear(input int seen, input int exp);
    check((seen >= exp - 1 && seen <= exp + 1) ? exp : seen, exp);
  endtask : checkNear

  // One APB transfer; the request holds until pready is sampled high.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task regWr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
    check({31'h0, err}, 32'h0);
  endtask : regWr

  task regRd(input logic [11:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
    check({31'h0, err}, {31'h0, expErr});
  endtask : regRd

  // Cycles from the mark to the first cpu tick must match the wake-up figure.
  task measureWake(input int exp);
    int mark;
    mark = cyc;
    do @(posedge clk); while (cpuClkTick_ff !== 1'b1 && cyc - mark < 9000);
    check((cyc - mark >= exp - 8 && cyc - mark <= exp + 16) ? 1 : 0, 1);
  endtask : measureWake

  task countWin(input int n, output int c, output int p, output int m, output int t,
                output int o);
    int c0, p0, m0, t0, o0;
    c0 = cpuCnt; p0 = perCnt; m0 = macCnt; t0 = togCnt; o0 = oeCnt;
    repeat (n) @(posedge clk);
    c = cpuCnt - c0; p = perCnt - p0; m = macCnt - m0; t = togCnt - t0; o = oeCnt - o0;
  endtask : countWin

  task summarize;
    $display("checks=%0d failures=%0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // Watchdog against a hang.
  initial begin
    #(50 * 60000);
    failures++;
    summarize();
  end

  initial begin : mainSeq
    int c, p, m, t, o;
    scg_src_e s;
    rst_n = 1'b0; otherRst_n = 1'b1; wakeReq = 1'b0; srcSel = SCG_SRC_RC; rtcOnXtal = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    oscPh = 3'h0; prevPin = 1'b0; cyc = 0; cpuCnt = 0; perCnt = 0; macCnt = 0; togCnt = 0;
    oeCnt = 0; failures = 0; checksDone = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    measureWake(224 * 4 + WAKE_DELAY_CYC);
    regRd(ADDR_TRIM, {24'h0, TRIM_FACTORY}, 1'b0);
    check({26'h0, rcTune_ff}, {26'h0, TRIM_FACTORY[5:0]});
    regRd(ADDR_DIVIDE, 32'h0, 1'b0);
    regRd(12'h260, 32'h0, 1'b1);
    regRd(ADDR_STATUS, 32'h31, 1'b0);
    // tick ratios at divide by one.
    countWin(400, c, p, m, t, o);
    checkNear(c, 100);
    checkNear(p, c / 2);
    checkNear(m, c / 2);
    // divide value of two gives one cpu tick per four oscillator ticks.
    regWr(ADDR_DIVIDE, 32'h2);
    countWin(320, c, p, m, t, o);
    checkNear(c, 20);
    regWr(ADDR_DIVIDE, 32'h0);
    // clock out enabled with tuning written.
    regWr(ADDR_TRIM, 32'h55);
    regRd(ADDR_TRIM, 32'h55, 1'b0);
    repeat (3) @(posedge clk);
    check({26'h0, rcTune_ff}, 32'h15);
    countWin(400, c, p, m, t, o);
    checkNear(t, c);
    check(o, 400);
    regRd(ADDR_STATUS, 32'h33, 1'b0);
    // real-time clock on the crystal blocks the output.
    rtcOnXtal <= 1'b1;
    countWin(8, c, p, m, t, o);
    check({30'h0, clkOutPinOe_ff, clkOutPin_ff}, 32'h0);
    rtcOnXtal <= 1'b0;
    regWr(ADDR_TRIM, 32'h15);
    countWin(8, c, p, m, t, o);
    check({30'h0, clkOutPinOe_ff, clkOutPin_ff}, 32'h0);
    // another reset keeps tuning but clears the divider.
    regWr(ADDR_DIVIDE, 32'h3);
    @(posedge clk) otherRst_n <= 1'b0;
    repeat (4) @(posedge clk);
    otherRst_n <= 1'b1;
    measureWake(224 * 4 + WAKE_DELAY_CYC + 3);
    regRd(ADDR_TRIM, 32'h15, 1'b0);
    regRd(ADDR_DIVIDE, 32'h0, 1'b0);
    // every source, restarted by a wake request, clock out requested.
    regWr(ADDR_TRIM, 32'h55);
    for (int i = 0; i < 6; i++) begin
      s = scg_src_e'(i);
      srcSel <= s;
      repeat (4) @(posedge clk);
      wakeReq <= 1'b1;
      @(posedge clk) wakeReq <= 1'b0;
      measureWake(((i < 3) ? 992 : 224) * ((i == 4) ? 8 : 4) + WAKE_DELAY_CYC);
      regRd(ADDR_STATUS, {25'h0, 3'(i), 2'h0, 1'(i > 2), 1'b1}, 1'b0);
    end
    summarize();
  end : mainSeq

endmodule : system_clock_generation_tb_top
